// [pkg/tjs_pkg.sv]
/*
 * Package for the track jump sequencer: register map, command codes,
 * state encoding and timing constants.
 * Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package tjs_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS = 50;          // 20 MHz
	localparam int T_SHORT_NS    = 233000;      // 233 us pulse
	localparam int T_LONG_NS     = 466000;      // 466 us pulse
	localparam int T_BRAKE_NS    = 60000000;    // 60 ms braking
	localparam int CYC_SHORT     = (T_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_LONG      = (T_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_BRAKE     = (T_BRAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Widths
	localparam int LEN_W  = 28;                 // Phase length counters
	localparam int PER_W  = 20;                 // Track period counter
	localparam logic [PER_W-1:0] PERIOD_DEF = 20'h007D0; // Period before first edge
	localparam logic [PER_W-1:0] PERIOD_MAX = 20'hFFFFF;

	// Register byte offsets
	localparam logic [3:0] OFS_CMD    = 4'h0;
	localparam logic [3:0] OFS_COUNT  = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] OFS_PERIOD = 4'hC;

	// Reset values
	localparam logic [7:0] COUNT_RST = 8'h08;

	// Status field positions
	localparam int ST_STATE_LSB = 0;            // [2:0] sequencer state
	localparam int ST_NEWMODE   = 4;
	localparam int ST_JP3       = 5;
	localparam int ST_THLDMODE  = 6;
	localparam int ST_CHKMODE   = 7;
	localparam int ST_TRACKING_LOOP_OFF      = 8;
	localparam int ST_MON       = 9;
	localparam int ST_GAIN      = 10;
	localparam int ST_CHKDIR    = 11;

	// Command codes
	localparam logic [7:0] C_OLD_JUMP   = 8'hA0;
	localparam logic [7:0] C_NEW_JUMP   = 8'hA1;
	localparam logic [7:0] C_J1_V1      = 8'h11;
	localparam logic [7:0] C_J1_V2      = 8'h12;
	localparam logic [7:0] C_J1_V3      = 8'h31;
	localparam logic [7:0] C_J1_V4      = 8'h52;
	localparam logic [7:0] C_J2         = 8'h10;
	localparam logic [7:0] C_J4         = 8'h13;
	localparam logic [7:0] C_J16        = 8'h14;
	localparam logic [7:0] C_J32        = 8'h30;
	localparam logic [7:0] C_J64        = 8'h15;
	localparam logic [7:0] C_J128       = 8'h17;
	localparam logic [7:0] C_CHECK256   = 8'h16;
	localparam logic [7:0] C_LOOP_OFF   = 8'h0F;
	localparam logic [7:0] C_LOOP_ON    = 8'h8F;
	localparam logic [7:0] C_BRAKE      = 8'h8C;
	localparam logic [7:0] C_HOLD_MODE  = 8'h21;
	localparam logic [7:0] C_HOLD_RST   = 8'h20;
	localparam logic [7:0] C_JP_THREE   = 8'hB6;
	localparam logic [7:0] C_JP_TWO     = 8'hB7;
	localparam logic [7:0] C_CHK_IN     = 8'hF0;
	localparam logic [7:0] C_CHK_OUT    = 8'hF8;
	localparam logic [7:0] C_TWOBYTE_RST = 8'hFF;
	localparam logic [7:0] C_OUT_BIT    = 8'h08;   // Outward variant of a jump

	// Phase length kinds
	typedef enum logic [1:0] {
		LK_NONE  = 2'b00,
		LK_SHORT = 2'b01,
		LK_LONG  = 2'b10,
		LK_HALF  = 2'b11
	} tjs_len_kind_t;

	// Sequencer states
	typedef enum logic [2:0] {
		S_IDLE    = 3'b000,
		S_ACCEL   = 3'b001,
		S_DECEL   = 3'b010,
		S_BRAKE   = 3'b011,
		S_SCAN256 = 3'b100,
		S_CHKWAIT = 3'b101,
		S_CHECK   = 3'b110
	} tjs_state_t;

	localparam logic [8:0] SCAN_TRACKS = 9'h100;   // 256 tracks

endpackage : tjs_pkg

// [hdl/tjs_sequencer.sv]
/*
 * Track jump sequencer: accel/decel/brake pulse generation, tracking brake,
 * 256-track scan and arbitrary track check, behind an Avalon-MM slave.
 * Assumes pin inputs are asynchronous to clk_in; qcode ready and velocity
 * mode come from logic on the same clock.
 */
// Functional notes
// - Variant one: 233us accel, 233us decel, brake
// - Variant two: half-period accel, mode-dependent decel
// - Variant three: variant-two timing, no brake
// - Variant four: loop-off low during brake
// - Two-track jump only in new mode
// - Four-track: two periods accel, 466us/2 decel
// - Sixteen-track: nine accel, seven/nine decel
// - 32/64/128 tracks: fixed period multiples, brake
// - 256 scan: loop off, no pulses, brake
// - Command register clears after full sequence
// - New jump command aborts running one
// - Brake loop-off samples mirror on edges
// - Mirror-to-data high, data-to-mirror low
// - Three-value command uses single tri-level pin
// - Check in/out distinct; two-byte reset cancels
// - Count loaded 8..254; count minus one
// - Check starts on read/write control fall
// - Loop off held high during check
// - Monitor rises at half, falls at end
// - Check repeats with same count until reset
// - Accel, decel, brake; gain raised in brake
// - Loop-off low only in velocity mode
// - Hold mode: loop off while hold high
`timescale 1ns/100ps

module tjs_sequencer
	import tjs_pkg::*;
#(
	parameter int CYC_SHORT_P = CYC_SHORT,
	parameter int CYC_LONG_P  = CYC_LONG,
	parameter int CYC_BRAKE_P = CYC_BRAKE
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// Servo pins
	input  wire logic        tracking_error_sense_in,
	input  wire logic        mirror_detect_in,
	input  wire logic        read_write_control_in,
	input  wire logic        tracking_hold_in,
	// Neighbouring logic
	input  wire logic        constant_linear_velocity_mode_in,
	input  wire logic        qcode_ready_in,
	// Outputs
	output logic             tracking_loop_off_out,
	output logic             tracking_gain_switch_out,
	output logic             jump_pulse_pos_out,
	output logic             jump_pulse_neg_out,
	output logic             jump_pulse_out,
	output logic             jump_pulse_oe_out,
	output logic             qcode_ready_monitor_out
);

	// Scale a track period by a count of half periods
	function automatic logic [LEN_W-1:0] scale_halves(input logic [PER_W-1:0] per,
		input logic [7:0] halves);
		logic [PER_W+7:0] prod;
		prod = per * halves;
		return LEN_W'(prod >> 1);
	endfunction : scale_halves

	// Phase length from its kind
	function automatic logic [LEN_W-1:0] phase_len(input tjs_len_kind_t kind,
		input logic [PER_W-1:0] per, input logic [7:0] halves);
		case (kind)
			LK_SHORT: return LEN_W'(CYC_SHORT_P);
			LK_LONG:  return LEN_W'(CYC_LONG_P);
			LK_HALF:  return scale_halves(per, halves);
			default:  return '0;
		endcase
	endfunction : phase_len

	// Synchronisers
	logic [1:0] tes_sync_r, hfl_sync_r, rwc_sync_r, tracking_hold_sync_r;
	logic       tes_d_r, rwc_d_r;

	// Bus
	logic        wait_r;
	logic [31:0] rdata_r;

	// Configuration and state
	tjs_state_t      state_r;
	logic [7:0]      cmd_r;
	logic [7:0]      count_r;
	logic            new_mode_r, jp3_r, hold_mode_r, loop_off_cmd_r;
	logic            chk_mode_r, chk_dir_r, chk_mon_r;
	logic            dir_out_r, has_brake_r, brake_low_r, brake_tracking_loop_off_r;
	logic [LEN_W-1:0] timer_r, dec_len_r;
	logic [8:0]      trk_r;
	logic [PER_W-1:0] per_cnt_r, period_r;

	// Output flops
	logic tracking_loop_off_r, tgl_r, jpp_r, jpn_r, jpl_r, jpoe_r, mon_r;

	// Decoded access
	logic       acc_wr, cmd_wr, tes_edge, tes_rise, rwc_fall;
	logic [7:0] wbyte;

	// Two-flop synchronisers for pin inputs
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tes_sync_r  <= 2'h0;
			hfl_sync_r  <= 2'h0;
			rwc_sync_r  <= 2'h3;
			tracking_hold_sync_r <= 2'h0;
			tes_d_r     <= 1'b0;
			rwc_d_r     <= 1'b1;
		end else begin
			tes_sync_r  <= {tes_sync_r[0], tracking_error_sense_in};
			hfl_sync_r  <= {hfl_sync_r[0], mirror_detect_in};
			rwc_sync_r  <= {rwc_sync_r[0], read_write_control_in};
			tracking_hold_sync_r <= {tracking_hold_sync_r[0], tracking_hold_in};
			tes_d_r     <= tes_sync_r[1];
			rwc_d_r     <= rwc_sync_r[1];
		end
	end

	// Edge detection on synchronised pins
	assign tes_edge = tes_sync_r[1] ^ tes_d_r;
	assign tes_rise = tes_sync_r[1] & ~tes_d_r;
	assign rwc_fall = ~rwc_sync_r[1] & rwc_d_r;

	// Bus write decode: a write takes effect when waitrequest is low and byte lane 0 is enabled
	assign acc_wr = avs_write_in & ~wait_r & avs_byteenable_in[0];
	assign cmd_wr = acc_wr & (avs_address_in == OFS_CMD);
	assign wbyte  = avs_writedata_in[7:0];

	// Avalon slave: one wait cycle, read data captured with the answer
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else if ((avs_read_in | avs_write_in) & wait_r) begin
			wait_r <= 1'b0;
			case (avs_address_in)
				OFS_CMD:    rdata_r <= {24'h000000, cmd_r};
				OFS_COUNT:  rdata_r <= {24'h000000, count_r};
				OFS_STATUS: rdata_r <= {20'h00000, chk_dir_r, tgl_r, mon_r, tracking_loop_off_r,
					chk_mode_r, hold_mode_r, jp3_r, new_mode_r, 1'b0, state_r};
				OFS_PERIOD: rdata_r <= {12'h000, period_r};
				default:    rdata_r <= 32'h0000_0000;
			endcase
		end else begin
			wait_r <= 1'b1;
		end
	end

	// Track period measurement between rising sense edges
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			per_cnt_r <= '0;
			period_r  <= PERIOD_DEF;
		end else if (tes_rise) begin
			period_r  <= per_cnt_r + PER_W'(1);
			per_cnt_r <= '0;
		end else if (per_cnt_r != PERIOD_MAX) begin
			per_cnt_r <= per_cnt_r + PER_W'(1);
		end
	end

	// Mode commands and track count register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			new_mode_r     <= 1'b0;
			jp3_r          <= 1'b0;
			hold_mode_r    <= 1'b0;
			loop_off_cmd_r <= 1'b0;
			count_r        <= COUNT_RST;
		end else begin
			if (acc_wr && avs_address_in == OFS_COUNT)
				count_r <= wbyte;
			if (cmd_wr) begin
				case (wbyte)
					C_OLD_JUMP:  new_mode_r     <= 1'b0;
					C_NEW_JUMP:  new_mode_r     <= 1'b1;
					C_JP_THREE:  jp3_r          <= 1'b1;
					C_JP_TWO:    jp3_r          <= 1'b0;
					C_HOLD_MODE: hold_mode_r    <= 1'b1;
					C_HOLD_RST:  hold_mode_r    <= 1'b0;
					C_LOOP_OFF:  loop_off_cmd_r <= 1'b1;
					C_LOOP_ON:   loop_off_cmd_r <= 1'b0;
					default:     ;
				endcase
			end
		end
	end

	// Jump profile decode for a written command
	tjs_len_kind_t acc_kind, dec_kind;
	logic [7:0]    acc_h, dec_h;
	logic          is_jump, brake_on, brake_low;
	always_comb begin
		acc_kind  = LK_NONE;
		dec_kind  = LK_NONE;
		acc_h     = 8'h00;
		dec_h     = 8'h00;
		is_jump   = 1'b1;
		brake_on  = 1'b1;
		brake_low = 1'b0;
		case (wbyte & ~C_OUT_BIT)
			C_J1_V1: begin
				acc_kind = LK_SHORT;
				dec_kind = LK_SHORT;
			end
			C_J1_V2, C_J1_V3, C_J1_V4: begin
				acc_kind = LK_HALF;
				acc_h    = 8'h01;
				dec_kind = new_mode_r ? LK_HALF : LK_SHORT;
				dec_h    = 8'h01;
				brake_on = ((wbyte & ~C_OUT_BIT) != C_J1_V3);
				brake_low = ((wbyte & ~C_OUT_BIT) == C_J1_V4);
			end
			C_J2: begin
				acc_kind = new_mode_r ? LK_HALF : LK_NONE;
				dec_kind = acc_kind;
				acc_h    = 8'h02;
				dec_h    = 8'h02;
				brake_on = 1'b0;
			end
			C_J4: begin
				acc_kind = LK_HALF;
				acc_h    = 8'h04;
				dec_kind = new_mode_r ? LK_HALF : LK_LONG;
				dec_h    = 8'h04;
			end
			C_J16: begin
				acc_kind = LK_HALF;
				acc_h    = 8'h12;
				dec_kind = LK_HALF;
				dec_h    = new_mode_r ? 8'h12 : 8'h0E;
			end
			C_J32: begin
				acc_kind = LK_HALF;
				acc_h    = 8'h24;
				dec_kind = LK_HALF;
				dec_h    = 8'h1C;
			end
			C_J64: begin
				acc_kind = LK_HALF;
				acc_h    = 8'h48;
				dec_kind = LK_HALF;
				dec_h    = 8'h38;
			end
			C_J128: begin
				acc_kind = LK_HALF;
				acc_h    = 8'h90;
				dec_kind = LK_HALF;
				dec_h    = 8'h70;
			end
			default: is_jump = 1'b0;
		endcase
		if (wbyte == C_CHECK256)
			is_jump = 1'b0;
	end

	// Sequencer: commands, phases, track scan and track check
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r     <= S_IDLE;
			cmd_r       <= 8'h00;
			timer_r     <= '0;
			dec_len_r   <= '0;
			dir_out_r   <= 1'b0;
			has_brake_r <= 1'b0;
			brake_low_r <= 1'b0;
			trk_r       <= 9'h000;
			chk_mode_r  <= 1'b0;
			chk_dir_r   <= 1'b0;
			chk_mon_r   <= 1'b0;
		end else if (cmd_wr && is_jump) begin
			// Abandon whatever runs and start the new jump
			cmd_r       <= wbyte;
			chk_mode_r  <= 1'b0;
			chk_mon_r   <= 1'b0;
			dir_out_r   <= wbyte[3];
			has_brake_r <= brake_on;
			brake_low_r <= brake_low;
			dec_len_r   <= phase_len(dec_kind, period_r, dec_h);
			timer_r     <= phase_len(acc_kind, period_r, acc_h);
			state_r     <= (acc_kind == LK_NONE) ? S_IDLE : S_ACCEL;
		end else if (cmd_wr && wbyte == C_CHECK256) begin
			cmd_r      <= wbyte;
			chk_mode_r <= 1'b0;
			chk_mon_r  <= 1'b0;
			trk_r      <= 9'h000;
			state_r    <= S_SCAN256;
		end else if (cmd_wr && wbyte == C_BRAKE) begin
			cmd_r       <= wbyte;
			chk_mode_r  <= 1'b0;
			chk_mon_r   <= 1'b0;
			brake_low_r <= 1'b0;
			timer_r     <= LEN_W'(CYC_BRAKE_P);
			state_r     <= S_BRAKE;
		end else if (cmd_wr && (wbyte == C_CHK_IN || wbyte == C_CHK_OUT)) begin
			chk_mode_r <= 1'b1;
			chk_dir_r  <= (wbyte == C_CHK_OUT);
			chk_mon_r  <= 1'b0;
			state_r    <= S_CHKWAIT;
		end else if (cmd_wr && wbyte == C_TWOBYTE_RST) begin
			chk_mode_r <= 1'b0;
			chk_mon_r  <= 1'b0;
			if (state_r == S_CHKWAIT || state_r == S_CHECK)
				state_r <= S_IDLE;
		end else begin
			case (state_r)
				S_ACCEL: begin
					if (timer_r <= LEN_W'(1)) begin
						timer_r <= dec_len_r;
						state_r <= S_DECEL;
					end else
						timer_r <= timer_r - LEN_W'(1);
				end
				S_DECEL: begin
					if (timer_r > LEN_W'(1))
						timer_r <= timer_r - LEN_W'(1);
					else if (has_brake_r) begin
						timer_r <= LEN_W'(CYC_BRAKE_P);
						state_r <= S_BRAKE;
					end else begin
						cmd_r   <= 8'h00;
						state_r <= S_IDLE;
					end
				end
				S_BRAKE: begin
					if (timer_r <= LEN_W'(1)) begin
						cmd_r   <= 8'h00;
						state_r <= S_IDLE;
					end else
						timer_r <= timer_r - LEN_W'(1);
				end
				S_SCAN256: begin
					if (tes_rise) begin
						if (trk_r == SCAN_TRACKS - 9'h001) begin
							timer_r     <= LEN_W'(CYC_BRAKE_P);
							brake_low_r <= 1'b0;
							state_r     <= S_BRAKE;
						end else
							trk_r <= trk_r + 9'h001;
					end
				end
				S_CHKWAIT: begin
					if (rwc_fall) begin
						trk_r   <= 9'h000;
						state_r <= S_CHECK;
					end
				end
				S_CHECK: begin
					if (tes_rise) begin
						if (trk_r + 9'h001 >= {1'b0, count_r} - 9'h001) begin
							trk_r     <= 9'h000;
							chk_mon_r <= 1'b0;
						end else begin
							trk_r <= trk_r + 9'h001;
							if (trk_r + 9'h001 >= ({1'b0, count_r} - 9'h001) >> 1)
								chk_mon_r <= 1'b1;
						end
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// Tracking brake: sample mirror detect on each sense edge
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			brake_tracking_loop_off_r <= 1'b0;
		else if (tes_edge)
			brake_tracking_loop_off_r <= hfl_sync_r[1];
	end

	// Output next values
	logic tracking_loop_off_nxt, pos_nxt, neg_nxt;
	always_comb begin
		pos_nxt = (state_r == S_ACCEL) ? ~dir_out_r : (state_r == S_DECEL) & dir_out_r;
		neg_nxt = (state_r == S_ACCEL) ? dir_out_r : (state_r == S_DECEL) & ~dir_out_r;
		if (!constant_linear_velocity_mode_in)
			tracking_loop_off_nxt = 1'b1;
		else if (hold_mode_r && tracking_hold_sync_r[1])
			tracking_loop_off_nxt = 1'b1;
		else if (state_r == S_SCAN256 || state_r == S_CHECK)
			tracking_loop_off_nxt = 1'b1;
		else if (state_r == S_BRAKE)
			tracking_loop_off_nxt = brake_low_r ? 1'b0 : brake_tracking_loop_off_r;
		else
			tracking_loop_off_nxt = loop_off_cmd_r;
	end

	// Registered outputs
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tracking_loop_off_r <= 1'b1;
			tgl_r  <= 1'b0;
			jpp_r  <= 1'b0;
			jpn_r  <= 1'b0;
			jpl_r  <= 1'b0;
			jpoe_r <= 1'b0;
			mon_r  <= 1'b0;
		end else begin
			tracking_loop_off_r <= tracking_loop_off_nxt;
			tgl_r  <= (state_r == S_BRAKE);
			jpp_r  <= ~jp3_r & pos_nxt;
			jpn_r  <= ~jp3_r & neg_nxt;
			jpl_r  <= jp3_r & pos_nxt;
			jpoe_r <= jp3_r & (pos_nxt | neg_nxt);
			mon_r  <= chk_mode_r ? chk_mon_r : qcode_ready_in;
		end
	end

	// Port drive
	assign avs_readdata_out         = rdata_r;
	assign avs_waitrequest_out      = wait_r;
	assign tracking_loop_off_out    = tracking_loop_off_r;
	assign tracking_gain_switch_out = tgl_r;
	assign jump_pulse_pos_out       = jpp_r;
	assign jump_pulse_neg_out       = jpn_r;
	assign jump_pulse_out           = jpl_r;
	assign jump_pulse_oe_out        = jpoe_r;
	assign qcode_ready_monitor_out  = mon_r;

endmodule : tjs_sequencer

// [verification/tjs_disc_model.sv]
/*
 * Disc and actuator stand-in: a spinning disc crossing tracks.
 * Assumes the bench clock; while run_in is low both lines stand still.
 */
`timescale 1ns/100ps

module tjs_disc_model #(
	parameter int HALF = 10
) (
	// Clock and enable
	input  wire logic clk_in,
	input  wire logic run_in,
	// Pickup lines
	output logic      sense_out = 1'b0,
	output logic      mirror_out = 1'b0
);
	int cnt_r = 0;

	// Sense toggles every HALF cycles; mirror trails it by a quarter track
	always @(posedge clk_in) begin
		if (run_in) begin
			cnt_r <= (cnt_r == 2 * HALF - 1) ? 0 : cnt_r + 1;
			if (cnt_r == 0 || cnt_r == HALF)
				sense_out <= ~sense_out;
			if (cnt_r == HALF / 2 || cnt_r == HALF + HALF / 2)
				mirror_out <= ~mirror_out;
		end
	end
endmodule : tjs_disc_model

// [verification/tjs_sequencer_sva.sv]
/*
 * Port checker for the track jump sequencer.
 * Assumes one clock domain with an asynchronous active-low reset.
 */
`timescale 1ns/100ps

module tjs_sequencer_chk
	import tjs_pkg::*;
#(
	parameter int CYC_BRAKE_P = CYC_BRAKE
) (
	// Clock, reset and bus handshake
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic avs_waitrequest_out,
	// Servo side
	input wire logic constant_linear_velocity_mode_in,
	input wire logic tracking_loop_off_out,
	input wire logic tracking_gain_switch_out,
	input wire logic jump_pulse_pos_out,
	input wire logic jump_pulse_neg_out,
	input wire logic jump_pulse_oe_out
);
	int brk_cnt_r;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// Length of the running braking period
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			brk_cnt_r <= 0;
		else
			brk_cnt_r <= tracking_gain_switch_out ? brk_cnt_r + 1 : 0;
	end

	a_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("bus request not answered next cycle");
	a_answer_once: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("answer cycle longer than one");
	a_pulse_excl: assert property (!(jump_pulse_pos_out && jump_pulse_neg_out))
		else $error("both jump pulse pins high");
	a_tri_excl: assert property (jump_pulse_oe_out |-> !jump_pulse_pos_out && !jump_pulse_neg_out)
		else $error("two-value pins active in three-value drive");
	a_brake_quiet: assert property (tracking_gain_switch_out
		|-> !jump_pulse_pos_out && !jump_pulse_neg_out && !jump_pulse_oe_out)
		else $error("jump pulse during braking");
	a_brake_max: assert property (brk_cnt_r <= CYC_BRAKE_P)
		else $error("braking period too long");
	a_clv_open: assert property (!constant_linear_velocity_mode_in ##1
		!constant_linear_velocity_mode_in |-> tracking_loop_off_out)
		else $error("loop closed outside velocity mode");
	a_reset_vals: assert property ($rose(rst_n_in) |-> tracking_loop_off_out
		&& !tracking_gain_switch_out && !jump_pulse_oe_out && avs_waitrequest_out)
		else $error("wrong output after reset");
endmodule : tjs_sequencer_chk

bind tjs_sequencer tjs_sequencer_chk #(.CYC_BRAKE_P(CYC_BRAKE_P)) u_chk (
	.clk_in, .rst_n_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out,
	.constant_linear_velocity_mode_in, .tracking_loop_off_out, .tracking_gain_switch_out,
	.jump_pulse_pos_out, .jump_pulse_neg_out, .jump_pulse_oe_out
);

// [verification/tb.sv]
/*
 * Self-checking bench for the track jump sequencer: bus tasks, mode cases,
 * a table of jump commands, then abort, track check and reset cases.
 * Assumes the disc model drives the sense and mirror lines.
 */
`timescale 1ns/100ps

module tb
	import tjs_pkg::*;
;
	localparam int HALF = 10;
	localparam int SH = 20;
	localparam int BK = 200;
	typedef struct {logic [7:0] cmd; logic nm; int acc; int dec; int brk;} tjs_row_t;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [3:0] avs_address_in = 4'h0;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [3:0] avs_byteenable_in = 4'hF;
	logic [31:0] avs_readdata_out, q;
	logic avs_waitrequest_out, spin = 1'b0, tracking_error_sense_in, mirror_detect_in;
	logic read_write_control_in = 1'b1, tracking_hold_in = 1'b0, qcode_ready_in = 1'b0;
	logic constant_linear_velocity_mode_in = 1'b1;
	logic tracking_loop_off_out, tracking_gain_switch_out, jump_pulse_pos_out;
	logic jump_pulse_neg_out, jump_pulse_out, jump_pulse_oe_out, qcode_ready_monitor_out;
	int fails = 0, checked = 0, n_p = 0, n_n = 0, n_g = 0, n_f = 0, n_oe = 0, k, f0, hi;
	tjs_row_t rows[19] = '{
		'{8'h11, 0, -1, -1, 1}, '{8'h1A, 0, 1, -1, 1}, '{8'h31, 0, 1, -1, 0},
		'{8'h52, 0, 1, -1, 1}, '{8'h10, 0, 0, 0, 0}, '{8'h1B, 0, 4, -2, 1},
		'{8'h14, 0, 18, 14, 1}, '{8'h38, 0, 36, 28, 1}, '{8'h15, 0, 72, 56, 1},
		'{8'h17, 0, 144, 112, 1}, '{8'h8C, 0, 0, 0, 1}, '{8'h19, 1, -1, -1, 1},
		'{8'h12, 1, 1, 1, 1}, '{8'h39, 1, 1, 1, 0}, '{8'h10, 1, 2, 2, 0},
		'{8'h13, 1, 4, 4, 1}, '{8'h1C, 1, 18, 18, 1}, '{8'h30, 1, 36, 28, 1},
		'{8'h8C, 1, 0, 0, 1}};

	tjs_sequencer #(.CYC_SHORT_P(SH), .CYC_LONG_P(40), .CYC_BRAKE_P(BK)) dut (
		.clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
		.tracking_error_sense_in, .mirror_detect_in, .read_write_control_in,
		.tracking_hold_in, .constant_linear_velocity_mode_in, .qcode_ready_in,
		.tracking_loop_off_out, .tracking_gain_switch_out, .jump_pulse_pos_out,
		.jump_pulse_neg_out, .jump_pulse_out, .jump_pulse_oe_out, .qcode_ready_monitor_out);
	tjs_disc_model #(.HALF(HALF)) model (.clk_in, .run_in(spin),
		.sense_out(tracking_error_sense_in), .mirror_out(mirror_detect_in));

	// Clock
	always #25 clk_in = ~clk_in;

	// Drive cycles per polarity, braking, open loop in braking, tri-level drive
	always @(posedge clk_in) begin
		n_p <= n_p + int'(jump_pulse_pos_out | (jump_pulse_oe_out & jump_pulse_out));
		n_n <= n_n + int'(jump_pulse_neg_out | (jump_pulse_oe_out & ~jump_pulse_out));
		n_g <= n_g + int'(tracking_gain_switch_out);
		n_f <= n_f + int'(tracking_gain_switch_out & tracking_loop_off_out);
		n_oe <= n_oe + int'(jump_pulse_oe_out);
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= w;
		avs_read_in <= ~w;
		do begin
			@(posedge clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 20);
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		chk(avs_waitrequest_out, 1'b0);
	endtask : bus

	task wrt(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d});
	endtask : wrt

	task rdc(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rdc

	function automatic int len(input int h);
		return (h == -1) ? SH : (h == -2) ? 2 * SH : h * HALF;
	endfunction : len

	task mon_wait(input logic v);
		k = 0;
		while (qcode_ready_monitor_out !== v && k < 400) begin
			@(posedge clk_in);
			k++;
			f0 += int'(tracking_loop_off_out !== 1'b1);
		end
	endtask : mon_wait

	task run(input tjs_row_t r);
		int p0, m0, g0, c0, n;
		wrt(OFS_CMD, r.cmd);
		repeat (2) @(posedge clk_in);
		p0 = n_p;
		m0 = n_n;
		g0 = n_g;
		c0 = n_f;
		n = 0;
		do begin
			bus(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while (q[2:0] !== 3'h0 && n < 3000);
		chk(q[2:0], 3'h0);
		chk(r.cmd[3] ? n_n - m0 : n_p - p0, len(r.acc));
		chk(r.cmd[3] ? n_p - p0 : n_n - m0, len(r.dec));
		chk(n_g - g0, r.brk * BK);
		if ((r.cmd & 8'hF7) == C_J1_V4)
			chk(n_f - c0, 0);
		rdc(OFS_CMD, (r.acc | r.dec | r.brk) == 0 ? r.cmd : 8'h00);
	endtask : run

	task end_of_test;
		if (fails == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test

	// Watchdog against a hung handshake or sequence
	initial begin
		repeat (60000) @(posedge clk_in);
		fails++;
		end_of_test();
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rdc(OFS_COUNT, COUNT_RST);
		rdc(OFS_CMD, 32'h0);
		rdc(4'h2, 32'h0);
		avs_byteenable_in <= 4'h0;
		wrt(OFS_COUNT, 8'h20);
		avs_byteenable_in <= 4'hF;
		rdc(OFS_COUNT, COUNT_RST);
		chk(tracking_loop_off_out, 1'b0);
		constant_linear_velocity_mode_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		chk(tracking_loop_off_out, 1'b1);
		constant_linear_velocity_mode_in <= 1'b1;
		wrt(OFS_CMD, C_HOLD_MODE);
		tracking_hold_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		chk(tracking_loop_off_out, 1'b1);
		tracking_hold_in <= 1'b0;
		wrt(OFS_CMD, C_HOLD_RST);
		wrt(OFS_CMD, C_LOOP_OFF);
		repeat (3) @(posedge clk_in);
		chk(tracking_loop_off_out, 1'b1);
		wrt(OFS_CMD, C_LOOP_ON);
		repeat (3) @(posedge clk_in);
		chk(tracking_loop_off_out, 1'b0);
		spin <= 1'b1;
		repeat (200) @(posedge clk_in);
		spin <= 1'b0;
		rdc(OFS_PERIOD, 2 * HALF);
		foreach (rows[i]) begin
			wrt(OFS_CMD, rows[i].nm ? C_NEW_JUMP : C_OLD_JUMP);
			run(rows[i]);
		end
		// Three-value drive of a new-mode single-track jump
		wrt(OFS_CMD, C_JP_THREE);
		run('{C_J1_V1, 1'b1, -1, -1, 1});
		chk(n_oe, 2 * SH);
		wrt(OFS_CMD, C_JP_TWO);
		// New command during braking, then during acceleration
		wrt(OFS_CMD, C_J4);
		repeat (100) @(posedge clk_in);
		run('{C_J1_V1, 1'b1, -1, -1, 1});
		wrt(OFS_CMD, C_OLD_JUMP);
		wrt(OFS_CMD, C_J128);
		repeat (30) @(posedge clk_in);
		run('{8'h19, 1'b0, -1, -1, 1});
		spin <= 1'b1;
		run('{C_CHECK256, 1'b0, 0, 0, 1});
		wrt(OFS_COUNT, 8'h08);
		wrt(OFS_CMD, C_CHK_IN);
		read_write_control_in <= 1'b0;
		mon_wait(1'b1);
		f0 = 0;
		mon_wait(1'b0);
		hi = k;
		mon_wait(1'b1);
		chk(hi, 4 * 2 * HALF);
		chk(hi + k, 7 * 2 * HALF);
		chk(f0, 0);
		read_write_control_in <= 1'b1;
		wrt(OFS_CMD, C_TWOBYTE_RST);
		rdc(OFS_STATUS, 32'h0000_0000);
		qcode_ready_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		chk(qcode_ready_monitor_out, 1'b1);
		qcode_ready_in <= 1'b0;
		wrt(OFS_CMD, C_CHK_OUT);
		read_write_control_in <= 1'b0;
		mon_wait(1'b1);
		mon_wait(1'b0);
		chk(k, 4 * 2 * HALF);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(q & 32'h0000_0887, 32'h0000_0886);
		wrt(OFS_CMD, C_TWOBYTE_RST);
		read_write_control_in <= 1'b1;
		run('{C_BRAKE, 1'b0, 0, 0, 1});
		spin <= 1'b0;
		wrt(OFS_COUNT, 8'h30);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rdc(OFS_COUNT, COUNT_RST);
		end_of_test();
	end
endmodule : tb
